// *** rtl/mmd_defs.vh ***
`ifndef MMD_DEFS_VH
`define MMD_DEFS_VH

// register offsets
`define MMD_OFS_MAP_CTRL 16'h0FD0
`define MMD_OFS_COMMIT_KEY 16'h0FD1
`define MMD_OFS_READBACK 16'h0FD2

// reset values and fields
`define MMD_MAP_CTRL_RST 8'h40
`define MMD_BOOT_SEL_BIT 4
`define MMD_COMMIT_CODE 8'hD5
`define MMD_RDATA_NONE 8'h00
`define MMD_FILL_BYTE 8'hFF

// boot overlay window
`define MMD_BOOT_LO 16'h1000
`define MMD_BOOT_HI 16'h17FF
`define MMD_BOOT_AW 11

// flash
`define MMD_FLASH_LO 16'h8000
`define MMD_FLASH_HI 16'hFFFF

// special function register windows
`define MMD_SFR1_LO 16'h0000
`define MMD_SFR1_HI 16'h003F
`define MMD_SFR2_LO 16'h0F00
`define MMD_SFR2_HI 16'h0FFF
`define MMD_SFR3_LO 16'h0E40
`define MMD_SFR3_HI 16'h0EFF

// ram
`define MMD_RAM_LO 16'h0040
`define MMD_RAM_HI 16'h083F

// code target encodings
`define MMD_CT_NONE 2'h0
`define MMD_CT_FLASH 2'h1
`define MMD_CT_BOOT 2'h2
`define MMD_CT_SOFT_INT 2'h3

`endif

// *** rtl/mmd_decoder.v ***
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - after reset the boot ROM is absent from code and data spaces
// - effective boot select 1 maps 0x1000-0x17FF to boot ROM, both spaces
// - control writes land in a holding stage; decoding uses the effective stage
// - writing 0xD5 to the key register commits holding to effective; others ignored
// - a read-only readback register shows the effective control value
// - code addresses 0x8000-0xFFFF decode to flash
// - data reads in 0x8000-0xFFFF decode to flash
// - data windows 0x0000-0x003F, 0x0F00-0x0FFF, 0x0E40-0x0EFF decode to SFRs
// - data addresses 0x0040-0x083F decode to RAM
// - overlay range data reads give 0xFF while the overlay is off
// - only the lowest 2 Kbytes of boot ROM are reachable
// - overlay range fetches give flash or a software interrupt opcode when off
`include "mmd_defs.vh"

module mmd_decoder #(
    parameter [15:0] FLASH_CODE_BASE = `MMD_FLASH_LO,
    parameter [7:0] SOFT_INT_OPCODE = 8'hFF
) (
    input wire clk_sys_i,
    input wire rstn_i,
    input wire ce_i,
    // register port
    input wire [15:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [7:0] reg_rdata_o,
    // code fetch side
    input wire code_req_i,
    input wire [15:0] code_addr_i,
    output wire code_valid_o,
    output wire [1:0] code_target_o,
    output wire [`MMD_BOOT_AW-1:0] code_boot_addr_o,
    output wire [7:0] code_fixed_data_o,
    // data access side
    input wire data_req_i,
    input wire data_wr_i,
    input wire [15:0] data_addr_i,
    output wire data_valid_o,
    output wire data_sfr_sel_o,
    output wire data_ram_sel_o,
    output wire data_boot_sel_o,
    output wire data_flash_sel_o,
    output wire data_fill_sel_o,
    output wire [`MMD_BOOT_AW-1:0] data_boot_addr_o,
    output wire [7:0] data_fixed_data_o,
    // status
    output wire boot_map_select_o,
    output wire commit_strobe_o
);

    function in_range;
        input [15:0] a;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    function in_boot;
        input [15:0] a;
        begin
            in_boot = in_range(a, `MMD_BOOT_LO, `MMD_BOOT_HI);
        end
    endfunction

    function in_flash;
        input [15:0] a;
        begin
            in_flash = in_range(a, `MMD_FLASH_LO, `MMD_FLASH_HI);
        end
    endfunction

    function in_ram;
        input [15:0] a;
        begin
            in_ram = in_range(a, `MMD_RAM_LO, `MMD_RAM_HI);
        end
    endfunction

    function in_sfr;
        input [15:0] a;
        begin
            in_sfr = in_range(a, `MMD_SFR1_LO, `MMD_SFR1_HI)
                || in_range(a, `MMD_SFR2_LO, `MMD_SFR2_HI)
                || in_range(a, `MMD_SFR3_LO, `MMD_SFR3_HI);
        end
    endfunction

    function reg_hit;
        input [15:0] a;
        input [15:0] ofs;
        begin
            reg_hit = (a == ofs);
        end
    endfunction

    function [`MMD_BOOT_AW-1:0] boot_offset;
        input [15:0] a;
        begin
            boot_offset = a[`MMD_BOOT_AW-1:0];
        end
    endfunction

    // map control, two stages
    reg [7:0] map_hold_q;
    reg [7:0] map_hold_d;
    reg [7:0] map_eff_q;
    reg [7:0] map_eff_d;
    reg commit_q;
    reg commit_d;
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;

    wire ctrl_hit;
    wire key_hit;
    wire boot_on;

    assign ctrl_hit = reg_wr_i && reg_hit(reg_addr_i, `MMD_OFS_MAP_CTRL);
    assign key_hit = reg_wr_i && reg_hit(reg_addr_i, `MMD_OFS_COMMIT_KEY)
        && (reg_wdata_i == `MMD_COMMIT_CODE);
    assign boot_on = map_eff_q[`MMD_BOOT_SEL_BIT];

    always @* begin
        map_hold_d = map_hold_q;
        if (ctrl_hit) begin
            map_hold_d = reg_wdata_i;
        end
    end

    always @* begin
        map_eff_d = map_eff_q;
        commit_d = 1'b0;
        if (key_hit) begin
            map_eff_d = map_hold_q;
            commit_d = 1'b1;
        end
    end

    always @* begin
        rdata_d = `MMD_RDATA_NONE;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `MMD_OFS_MAP_CTRL: begin
                    rdata_d = map_hold_q;
                end
                `MMD_OFS_READBACK: begin
                    rdata_d = map_eff_q;
                end
                `MMD_OFS_COMMIT_KEY: begin
                    rdata_d = `MMD_RDATA_NONE;
                end
                default: begin
                    rdata_d = `MMD_RDATA_NONE;
                end
            endcase
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            map_hold_q <= `MMD_MAP_CTRL_RST;
            map_eff_q <= `MMD_MAP_CTRL_RST;
            commit_q <= 1'b0;
            rdata_q <= `MMD_RDATA_NONE;
        end else if (ce_i) begin
            map_hold_q <= map_hold_d;
            map_eff_q <= map_eff_d;
            commit_q <= commit_d;
            rdata_q <= rdata_d;
        end
    end

    // code space decode
    reg code_valid_q;
    reg code_valid_d;
    reg [1:0] code_target_q;
    reg [1:0] code_target_d;
    reg [`MMD_BOOT_AW-1:0] code_boot_addr_q;
    reg [7:0] code_fixed_q;
    reg [7:0] code_fixed_d;

    always @* begin
        code_valid_d = code_req_i;
        code_target_d = `MMD_CT_NONE;
        code_fixed_d = `MMD_RDATA_NONE;
        if (in_boot(code_addr_i)) begin
            if (boot_on) begin
                code_target_d = `MMD_CT_BOOT;
            end else if (code_addr_i >= FLASH_CODE_BASE) begin
                code_target_d = `MMD_CT_FLASH;
            end else begin
                code_target_d = `MMD_CT_SOFT_INT;
                code_fixed_d = SOFT_INT_OPCODE;
            end
        end else if (in_flash(code_addr_i)) begin
            code_target_d = `MMD_CT_FLASH;
        end else if (code_addr_i >= FLASH_CODE_BASE) begin
            code_target_d = `MMD_CT_FLASH;
        end else begin
            // unmapped fetches trap rather than run stray data
            code_target_d = `MMD_CT_SOFT_INT;
            code_fixed_d = SOFT_INT_OPCODE;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            code_valid_q <= 1'b0;
            code_target_q <= `MMD_CT_NONE;
            code_boot_addr_q <= {`MMD_BOOT_AW{1'b0}};
            code_fixed_q <= `MMD_RDATA_NONE;
        end else if (ce_i) begin
            code_valid_q <= code_valid_d;
            if (code_req_i) begin
                code_target_q <= code_target_d;
                code_boot_addr_q <= boot_offset(code_addr_i);
                code_fixed_q <= code_fixed_d;
            end
        end
    end

    // data space decode
    reg data_valid_q;
    reg data_valid_d;
    reg [7:0] data_fixed_d;
    reg sfr_q;
    reg ram_q;
    reg boot_q;
    reg flash_q;
    reg fill_q;
    reg sfr_d;
    reg ram_d;
    reg boot_d;
    reg flash_d;
    reg fill_d;
    reg [`MMD_BOOT_AW-1:0] data_boot_addr_q;
    reg [7:0] data_fixed_q;

    always @* begin
        data_valid_d = data_req_i;
        sfr_d = 1'b0;
        ram_d = 1'b0;
        boot_d = 1'b0;
        flash_d = 1'b0;
        fill_d = 1'b0;
        data_fixed_d = `MMD_RDATA_NONE;
        if (in_sfr(data_addr_i)) begin
            sfr_d = 1'b1;
        end else if (in_ram(data_addr_i)) begin
            ram_d = 1'b1;
        end else if (in_boot(data_addr_i)) begin
            if (boot_on) begin
                boot_d = 1'b1;
            end else if (!data_wr_i) begin
                fill_d = 1'b1;
                data_fixed_d = `MMD_FILL_BYTE;
            end
        end else if (in_flash(data_addr_i)) begin
            // flash is read-only from the data side
            flash_d = !data_wr_i;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            data_valid_q <= 1'b0;
            sfr_q <= 1'b0;
            ram_q <= 1'b0;
            boot_q <= 1'b0;
            flash_q <= 1'b0;
            fill_q <= 1'b0;
            data_boot_addr_q <= {`MMD_BOOT_AW{1'b0}};
            data_fixed_q <= `MMD_RDATA_NONE;
        end else if (ce_i) begin
            data_valid_q <= data_valid_d;
            if (data_req_i) begin
                sfr_q <= sfr_d;
                ram_q <= ram_d;
                boot_q <= boot_d;
                flash_q <= flash_d;
                fill_q <= fill_d;
                data_boot_addr_q <= boot_offset(data_addr_i);
                data_fixed_q <= data_fixed_d;
            end
        end
    end

    assign reg_rdata_o = rdata_q;
    assign code_valid_o = code_valid_q;
    assign code_target_o = code_target_q;
    assign code_boot_addr_o = code_boot_addr_q;
    assign code_fixed_data_o = code_fixed_q;
    assign data_valid_o = data_valid_q;
    assign data_sfr_sel_o = sfr_q;
    assign data_ram_sel_o = ram_q;
    assign data_boot_sel_o = boot_q;
    assign data_flash_sel_o = flash_q;
    assign data_fill_sel_o = fill_q;
    assign data_boot_addr_o = data_boot_addr_q;
    assign data_fixed_data_o = data_fixed_q;
    assign boot_map_select_o = boot_on;
    assign commit_strobe_o = commit_q;

endmodule

// *** testbench/mmd_chk.sv ***
`timescale 1ns/1ns
module mmd_chk (
    input logic clk_sys_i,
    input logic rstn_i,
    input logic ce_i,
    input logic [15:0] reg_addr_i,
    input logic [7:0] reg_wdata_i,
    input logic reg_wr_i,
    input logic code_req_i,
    input logic [15:0] code_addr_i,
    input logic [1:0] code_target_o,
    input logic data_req_i,
    input logic data_wr_i,
    input logic [15:0] data_addr_i,
    input logic data_sfr_sel_o,
    input logic data_ram_sel_o,
    input logic data_boot_sel_o,
    input logic data_fill_sel_o,
    input logic [10:0] data_boot_addr_o,
    input logic boot_map_select_o,
    input logic commit_strobe_o
);
    default clocking dcb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire cr = code_req_i && ce_i;
    wire dq = data_req_i && ce_i;
    wire dr = dq && !data_wr_i;
    wire dw = data_addr_i[15:11] == 5'h02;
    wire [10:0] dlo = data_addr_i[10:0];
    wire kh = reg_wr_i && ce_i && reg_addr_i == 16'h0FD1 && reg_wdata_i == 8'hD5;
    sequence s_key;
        reg_wr_i && ce_i && reg_addr_i == 16'h0FD1 && reg_wdata_i == 8'hD5;
    endsequence
    sequence s_pulse;
        commit_strobe_o ##1 !commit_strobe_o;
    endsequence
    property p_commit; s_key ##1 !reg_wr_i |-> s_pulse; endproperty
    a_commit: assert property (p_commit) else $error("commit pulse");
    property p_hold; $changed(boot_map_select_o) |-> commit_strobe_o; endproperty
    a_hold: assert property (p_hold) else $error("select moved");
    property p_cboot; cr && boot_map_select_o && code_addr_i[15:11] == 5'h02 |=> code_target_o == 2'h2; endproperty
    a_cboot: assert property (p_cboot) else $error("boot fetch");
    property p_cflash; cr && code_addr_i[15] |=> code_target_o == 2'h1; endproperty
    a_cflash: assert property (p_cflash) else $error("flash fetch");
    property p_fill; dr && dw && !boot_map_select_o |=> data_fill_sel_o && !data_boot_sel_o; endproperty
    a_fill: assert property (p_fill) else $error("fill read");
    property p_dboot; dr && dw && boot_map_select_o |=> data_boot_sel_o && data_boot_addr_o == $past(dlo); endproperty
    a_dboot: assert property (p_dboot) else $error("boot read");
    property p_ram; dq && data_addr_i inside {[16'h0040:16'h083F]} |=> data_ram_sel_o; endproperty
    a_ram: assert property (p_ram) else $error("ram select");
    property p_sfr; dq && (data_addr_i <= 16'h003F || data_addr_i >= 16'h0E40 && data_addr_i <= 16'h0FFF) |=> data_sfr_sel_o; endproperty
    a_sfr: assert property (p_sfr) else $error("sfr select");
    property p_keyonly; commit_strobe_o |-> $past(kh); endproperty
    a_keyonly: assert property (p_keyonly) else $error("stray commit");
endmodule
bind mmd_decoder mmd_chk u_chk (.clk_sys_i, .rstn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .code_req_i, .code_addr_i, .code_target_o, .data_req_i, .data_wr_i, .data_addr_i,
    .data_sfr_sel_o, .data_ram_sel_o, .data_boot_sel_o, .data_fill_sel_o, .data_boot_addr_o,
    .boot_map_select_o, .commit_strobe_o);

// *** testbench/mmd_cpu_model.sv ***
`timescale 1ns/1ns
module mmd_cpu_model (
    input logic clk_sys_i,
    output logic code_req_o = 1'b0,
    output logic [15:0] code_addr_o = 16'h0000,
    output logic data_req_o = 1'b0,
    output logic data_wr_o = 1'b0,
    output logic [15:0] data_addr_o = 16'h0000
);
    // one cycle requests; no reserved sfr address is issued
    task fetch(input logic [15:0] a);
        @(posedge clk_sys_i);
        code_req_o <= 1'b1;
        code_addr_o <= a;
        @(posedge clk_sys_i);
        code_req_o <= 1'b0;
        code_addr_o <= ~a;
        #1;
    endtask
    task acc(input logic [15:0] a, input logic w);
        @(posedge clk_sys_i);
        data_req_o <= 1'b1;
        data_wr_o <= w;
        data_addr_o <= a;
        @(posedge clk_sys_i);
        data_req_o <= 1'b0;
        data_wr_o <= ~w;
        data_addr_o <= ~a;
        #1;
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    logic clk_sys_i = 0, rstn_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00, v;
    wire [7:0] rdat, cfd, dfd;
    wire creq, dreq, dwr, bsel, cval, dval, cstb;
    wire [15:0] cadr, dadr;
    wire [1:0] ctgt;
    wire [10:0] dba, cba;
    wire [4:0] dsel;
    int err_total = 0, checks = 0;
    mmd_cpu_model cpu (.clk_sys_i(clk_sys_i), .code_req_o(creq), .code_addr_o(cadr),
        .data_req_o(dreq), .data_wr_o(dwr), .data_addr_o(dadr));
    mmd_decoder uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdat),
        .code_req_i(creq), .code_addr_i(cadr), .code_valid_o(cval), .code_target_o(ctgt),
        .code_boot_addr_o(cba), .code_fixed_data_o(cfd), .data_req_i(dreq), .data_wr_i(dwr),
        .data_addr_i(dadr), .data_valid_o(dval), .data_sfr_sel_o(dsel[4]),
        .data_ram_sel_o(dsel[3]), .data_boot_sel_o(dsel[2]), .data_flash_sel_o(dsel[1]),
        .data_fill_sel_o(dsel[0]), .data_boot_addr_o(dba), .data_fixed_data_o(dfd),
        .boot_map_select_o(bsel), .commit_strobe_o(cstb));
    always #5 clk_sys_i = ~clk_sys_i;
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [15:0] a);
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        v = rdat;
    endtask
    task t_reset;
        chk("sel", bsel, 1'b0);
        chk("cstb", cstb, 1'b0);
        rd(16'h0FD0);
        chk("ctrl", v, 8'h40);
        @(posedge clk_sys_i);
        #1;
        chk("rdat", rdat, 8'h00);
        rd(16'h0FD2);
        chk("rdbk", v, 8'h40);
        rd(16'h0FD1);
        chk("key", v, 8'h00);
    endtask
    task t_map;
        logic [15:0] da [10] = '{16'h0000, 16'h003F, 16'h0040, 16'h083F, 16'h0840,
            16'h0E40, 16'h0FFF, 16'h8000, 16'hFFFF, 16'h1000};
        logic [4:0] ds [10] = '{5'h10, 5'h10, 5'h08, 5'h08, 5'h00, 5'h10, 5'h10, 5'h02, 5'h02, 5'h01};
        for (int i = 0; i < 10; i++) begin
            cpu.acc(da[i], 1'b0);
            chk("dsel", dsel, ds[i]);
        end
        chk("fill", dfd, 8'hFF);
        chk("dval", dval, 1'b1);
        cpu.acc(16'h8000, 1'b1);
        chk("dsel", dsel, 5'h00);
        cpu.fetch(16'h8000);
        chk("tgt", ctgt, 2'h1);
        chk("cval", cval, 1'b1);
        chk("cfd", cfd, 8'h00);
        cpu.fetch(16'h1000);
        chk("tgt", ctgt, 2'h3);
        chk("cfd", cfd, 8'hFF);
        @(posedge clk_sys_i);
        #1;
        chk("cval", cval, 1'b0);
        chk("tgt", ctgt, 2'h3);
    endtask
    task t_commit;
        wr(16'h0FD0, 8'h50);
        chk("sel", bsel, 1'b0);
        rd(16'h0FD2);
        chk("rdbk", v, 8'h40);
        wr(16'h0FD1, 8'hD4);
        chk("sel", bsel, 1'b0);
        chk("cstb", cstb, 1'b0);
        wr(16'h0FD1, 8'hD5);
        chk("sel", bsel, 1'b1);
        chk("cstb", cstb, 1'b1);
        rd(16'h0FD2);
        chk("rdbk", v, 8'h50);
        wr(16'h0FD2, 8'h00);
        rd(16'h0FD2);
        chk("rdbk", v, 8'h50);
        cpu.acc(16'h17FF, 1'b0);
        chk("dba", {dsel, dba}, 16'h27FF);
        cpu.fetch(16'h17FE);
        chk("tgt", ctgt, 2'h2);
        chk("cba", cba, 16'h07FE);
        wr(16'h0FD0, 8'h40);
        wr(16'h0FD1, 8'hD5);
        cpu.acc(16'h1000, 1'b0);
        chk("dsel", dsel, 5'h01);
    endtask
    task t_rerun;
        wr(16'h0FD0, 8'h50);
        wr(16'h0FD1, 8'hD5);
        chk("sel", bsel, 1'b1);
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        chk("sel", bsel, 1'b0);
        rd(16'h0FD0);
        chk("ctrl", v, 8'h40);
        cpu.acc(16'h1000, 1'b0);
        chk("dsel", dsel, 5'h01);
    endtask
    task t_freeze;
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(16'h0FD0, 8'h10);
        wr(16'h0FD1, 8'hD5);
        cpu.fetch(16'h8000);
        chk("cval", cval, 1'b0);
        chk("tgt", ctgt, 2'h0);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        chk("sel", bsel, 1'b0);
        rd(16'h0FD0);
        chk("ctrl", v, 8'h40);
    endtask
    task conclude;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset;
        t_map;
        t_commit;
        t_rerun;
        t_freeze;
        conclude;
    end
    initial begin
        #50000;
        err_total++;
        conclude;
    end
endmodule
